// ### verilog/status_report_regs.vh
// Constants for the status reporting and service request block.
// Included by the block's design file; definitions only.
`ifndef STATUS_REPORT_REGS_VH
`define STATUS_REPORT_REGS_VH

// Command codes on cmd_code, taken while cmd_valid is high
`define CMD_NONE        4'h0
`define CMD_CLS         4'h1
`define CMD_PRESET      4'h2
`define CMD_WR_SRE      4'h3
`define CMD_WR_ESE      4'h4
`define CMD_WR_PRE      4'h5
`define CMD_WR_PSC      4'h6
`define CMD_WR_OPER_EN  4'h7
`define CMD_WR_OPER_PTR 4'h8
`define CMD_WR_OPER_NTR 4'h9
`define CMD_WR_REG_EN   4'hA
`define CMD_WR_REG_PTR  4'hB
`define CMD_WR_REG_NTR  4'hC
`define CMD_OPC         4'hD
`define CMD_WAI         4'hE

// Query codes on query_code
`define QRY_STB         4'h0
`define QRY_ESR         4'h1
`define QRY_IST         4'h2
`define QRY_SRE         4'h3
`define QRY_ESE         4'h4
`define QRY_PRE         4'h5
`define QRY_PSC         4'h6
`define QRY_OPER_EVT    4'h7
`define QRY_OPER_COND   4'h8
`define QRY_OPER_EN     4'h9
`define QRY_OPER_PTR    4'hA
`define QRY_OPER_NTR    4'hB
`define QRY_REG_EVT     4'hC
`define QRY_REG_COND    4'hD
`define QRY_REG_EN      4'hE
`define QRY_REG_PTR     4'hF

// Widths and field positions
`define MASK_W          15
`define MASK_ONES       15'h7FFF
`define MASK_ZERO       15'h0000
`define STB_ERR_BIT     2
`define STB_QSUM_BIT    3
`define STB_MAV_BIT     4
`define STB_ESB_BIT     5
`define STB_MSS_BIT     6
`define STB_OSUM_BIT    7
`define ESR_OPC_BIT     0
`define PSC_RESET       1'b1

`endif

// ### verilog/status_reporting_service_request.v
// Status byte, standard event, service request, parallel poll, operation
// and regulating status structures with transition filters.
// Assumes a command decoder on the same clock issues one-cycle commands and
// queries; the condition inputs, ques_summary_in and err_queue_nonempty are synced here, other inputs are not.
`include "status_report_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module status_reporting_service_request (
  // Clock, reset and enable
  input  wire          clock,
  input  wire          rst_n,
  input  wire          clk_en,
  // Power-on pulse from supervisor logic
  input  wire          power_on,
  // Command port
  input  wire          cmd_valid,
  input  wire [3:0]    cmd_code,
  input  wire [15:0]   cmd_data,
  output reg           cmd_ready,
  // Query port
  input  wire          query_valid,
  input  wire [3:0]    query_code,
  output reg           query_done,
  output reg  [15:0]   query_data,
  // Event sources
  input  wire [14:0]   oper_cond_in,
  input  wire [14:0]   reg_cond_in,
  input  wire          ques_summary_in,
  input  wire          err_queue_nonempty,
  input  wire          msg_available,
  input  wire [7:0]    std_event_set,
  input  wire          op_pending,
  // Side effects toward the queues
  output reg           err_queue_clear,
  // Bus messages
  output reg           srq_out,
  output reg           ist_out,
  output reg  [7:0]    status_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the asynchronous condition and flag inputs
  // The conditions, ques_summary_in and err_queue_nonempty lag their pins by two edges
  reg [31:0] sync1_q;
  reg [31:0] sync2_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 32'h00000000;
      sync2_q <= 32'h00000000;
    end else if (clk_en) begin
      sync1_q <= {oper_cond_in, reg_cond_in, ques_summary_in, err_queue_nonempty};
      sync2_q <= sync1_q;
    end
  end
  wire [14:0] oper_cond = sync2_q[31:17];
  wire [14:0] reg_cond  = sync2_q[16:2];
  wire        ques_sum  = sync2_q[1];
  wire        err_ne    = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [14:0] oper_prev_q;
  reg [14:0] oper_evt_q;
  reg [14:0] oper_en_q;
  reg [14:0] oper_ptr_q;
  reg [14:0] oper_ntr_q;
  reg [14:0] reg_prev_q;
  reg [14:0] reg_evt_q;
  reg [14:0] reg_en_q;
  reg [14:0] reg_ptr_q;
  reg [14:0] reg_ntr_q;
  reg        qhold_q;
  reg [3:0]  qhold_code_q;
  reg [7:0]  esr_q;
  reg [7:0]  ese_q;
  reg [7:0]  sre_q;
  reg [15:0] pre_q;
  reg        psc_q;
  reg        opc_arm_q;
  reg        wai_q;

  wire take_cmd = cmd_valid && cmd_ready;
  wire [14:0] wr_mask = cmd_data[14:0];

  // Filtered edge detection; the regulating event register feeds no summary
  // bit and is only read back by query.
  wire [14:0] oper_hit = (oper_cond & ~oper_prev_q & oper_ptr_q)
                       | (~oper_cond & oper_prev_q & oper_ntr_q);
  wire [14:0] reg_hit  = (reg_cond & ~reg_prev_q & reg_ptr_q)
                       | (~reg_cond & reg_prev_q & reg_ntr_q);

  wire oper_sum = |(oper_evt_q & oper_en_q);
  wire esb_sum  = |(esr_q & ese_q);

  // Status byte without bit 6
  wire [7:0] stb_raw;
  assign stb_raw[1:0]          = 2'h0;
  assign stb_raw[`STB_ERR_BIT]  = err_ne;
  assign stb_raw[`STB_QSUM_BIT] = ques_sum;
  assign stb_raw[`STB_MAV_BIT]  = msg_available;
  assign stb_raw[`STB_ESB_BIT]  = esb_sum;
  assign stb_raw[`STB_MSS_BIT]  = 1'b0;
  assign stb_raw[`STB_OSUM_BIT] = oper_sum;
  // Bit 6 is left out of the summary since it carries the summary itself
  wire mss = |(stb_raw & sre_q & 8'hBF);
  wire [7:0] stb_full = stb_raw | {1'b0, mss, 6'h00};
  wire ist = |(pre_q & {8'h00, stb_full});

  // A query that arrives while a wait holds commands is parked in one slot
  // and answered once nothing is pending; the controller waits for its done.
  wire       q_block = !cmd_ready && op_pending;
  wire       q_fire  = (query_valid || qhold_q) && !q_block;
  wire [3:0] q_sel   = qhold_q ? qhold_code_q : query_code;
  wire esr_read = q_fire && q_sel == `QRY_ESR;
  // Operation complete fires once the armed flag sees nothing pending
  wire opc_fire = opc_arm_q && !op_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Event registers: set wins over a clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oper_prev_q <= `MASK_ZERO;
      reg_prev_q  <= `MASK_ZERO;
      oper_evt_q  <= `MASK_ZERO;
      reg_evt_q   <= `MASK_ZERO;
      esr_q       <= 8'h00;
      opc_arm_q   <= 1'b0;
    end else if (clk_en) begin
      oper_prev_q <= oper_cond;
      reg_prev_q  <= reg_cond;
      if (take_cmd && cmd_code == `CMD_CLS) begin
        oper_evt_q <= oper_hit;
        reg_evt_q  <= reg_hit;
        esr_q      <= (std_event_set & 8'h7D) | {7'h00, opc_fire};
        opc_arm_q  <= 1'b0;
      end else begin
        if (q_fire && q_sel == `QRY_OPER_EVT)
          oper_evt_q <= oper_hit;
        else
          oper_evt_q <= oper_evt_q | oper_hit;
        if (q_fire && q_sel == `QRY_REG_EVT)
          reg_evt_q <= reg_hit;
        else
          reg_evt_q <= reg_evt_q | reg_hit;
        // RQC and PON are not implemented and stay zero
        if (esr_read)
          esr_q <= (std_event_set & 8'h7D) | {7'h00, opc_fire};
        else
          esr_q <= esr_q | (std_event_set & 8'h7D) | {7'h00, opc_fire};
        // A new operation-complete request in the cycle it fires is dropped
        if (opc_fire)
          opc_arm_q <= 1'b0;
        else if (take_cmd && cmd_code == `CMD_OPC)
          opc_arm_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables and filters
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oper_en_q  <= `MASK_ZERO;
      oper_ptr_q <= `MASK_ONES;
      oper_ntr_q <= `MASK_ZERO;
      reg_en_q   <= `MASK_ONES;
      reg_ptr_q  <= `MASK_ONES;
      reg_ntr_q  <= `MASK_ZERO;
      ese_q      <= 8'h00;
      sre_q      <= 8'h00;
      pre_q      <= 16'h0000;
      psc_q      <= `PSC_RESET;
      wai_q      <= 1'b0;
    end else if (clk_en) begin
      // Preset leaves the request, poll and power-on clear settings alone
      if (take_cmd) begin
        case (cmd_code)
          `CMD_PRESET: begin
            oper_en_q  <= `MASK_ZERO;
            oper_ptr_q <= `MASK_ONES;
            oper_ntr_q <= `MASK_ZERO;
            reg_en_q   <= `MASK_ONES;
            reg_ptr_q  <= `MASK_ONES;
            reg_ntr_q  <= `MASK_ZERO;
          end
          `CMD_WR_SRE:      sre_q      <= cmd_data[7:0] & 8'hBF;
          `CMD_WR_ESE:      ese_q      <= cmd_data[7:0];
          // Poll enable bit 15 stays zero since every mask write is 15 bits
          `CMD_WR_PRE:      pre_q      <= {1'b0, wr_mask};
          `CMD_WR_PSC:      psc_q      <= cmd_data[0];
          `CMD_WR_OPER_EN:  oper_en_q  <= wr_mask;
          `CMD_WR_OPER_PTR: oper_ptr_q <= wr_mask;
          `CMD_WR_OPER_NTR: oper_ntr_q <= wr_mask;
          `CMD_WR_REG_EN:   reg_en_q   <= wr_mask;
          `CMD_WR_REG_PTR:  reg_ptr_q  <= wr_mask;
          `CMD_WR_REG_NTR:  reg_ntr_q  <= wr_mask;
          `CMD_WAI:         wai_q      <= 1'b1;
          default: ;
        endcase
      end
      // Power-on clear comes last so it wins over a write in the same cycle,
      // while any other command taken then still lands
      if (power_on && psc_q) begin
        sre_q <= 8'h00;
        ese_q <= 8'h00;
        pre_q <= 16'h0000;
      end
      if (wai_q && !op_pending)
        wai_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query answers and registered outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qhold_q      <= 1'b0;
      qhold_code_q <= 4'h0;
    end else if (clk_en) begin
      // A second query while one is parked replaces it
      if (query_valid && q_block) begin
        qhold_q      <= 1'b1;
        qhold_code_q <= query_code;
      end else if (!q_block) begin
        qhold_q      <= 1'b0;
      end
    end
  end

  reg [15:0] qmux;
  always @* begin
    qmux = 16'h0000;
    case (q_sel)
      `QRY_STB:       qmux = {8'h00, stb_full};
      `QRY_ESR:       qmux = {8'h00, esr_q};
      `QRY_IST:       qmux = {15'h0000, ist};
      `QRY_SRE:       qmux = {8'h00, sre_q};
      `QRY_ESE:       qmux = {8'h00, ese_q};
      `QRY_PRE:       qmux = pre_q;
      `QRY_PSC:       qmux = {15'h0000, psc_q};
      `QRY_OPER_EVT:  qmux = {1'b0, oper_evt_q};
      `QRY_OPER_COND: qmux = {1'b0, oper_cond};
      `QRY_OPER_EN:   qmux = {1'b0, oper_en_q};
      `QRY_OPER_PTR:  qmux = {1'b0, oper_ptr_q};
      `QRY_OPER_NTR:  qmux = {1'b0, oper_ntr_q};
      `QRY_REG_EVT:   qmux = {1'b0, reg_evt_q};
      `QRY_REG_COND:  qmux = {1'b0, reg_cond};
      `QRY_REG_EN:    qmux = {1'b0, reg_en_q};
      default:        qmux = {1'b0, reg_ptr_q};
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready       <= 1'b1;
      query_done      <= 1'b0;
      query_data      <= 16'h0000;
      err_queue_clear <= 1'b0;
      srq_out         <= 1'b0;
      ist_out         <= 1'b0;
      status_byte     <= 8'h00;
    end else if (clk_en) begin
      // Ready drops the cycle after a WAI is taken while an operation is pending, so nothing slips past
      cmd_ready       <= !(wai_q || (take_cmd && cmd_code == `CMD_WAI))
                         || !op_pending;
      query_done      <= q_fire;
      query_data      <= q_fire ? qmux : query_data;
      err_queue_clear <= (take_cmd && cmd_code == `CMD_CLS) || (power_on && psc_q);
      // Request and ist follow the summaries one edge later
      srq_out         <= mss;
      ist_out         <= ist;
      status_byte     <= stb_full;
    end
  end

endmodule

`default_nettype wire

// ### bench/status_props.sv
// Port-level checker for the status reporting block.
// Bound to the block's top module; all inputs are its ports.
`include "status_report_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module status_props (
  // Clock, reset, enable and power-on
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        power_on,
  // Command and query ports
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic        cmd_ready,
  input wire logic        query_valid,
  input wire logic [3:0]  query_code,
  input wire logic        query_done,
  input wire logic [15:0] query_data,
  input wire logic        op_pending,
  // Messages
  input wire logic        err_queue_clear,
  input wire logic        srq_out,
  input wire logic [7:0]  status_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic take = clk_en && cmd_valid && cmd_ready;
  ////////////////////////////////////////
  property p_qdone; clk_en && cmd_ready |=> query_done == $past(query_valid); endproperty
  a_qdone: assert property (p_qdone) else $error("query done timing");
  property p_srq; srq_out == status_byte[6]; endproperty
  a_srq: assert property (p_srq) else $error("srq differs from mss");
  property p_wai; take && cmd_code == `CMD_WAI && op_pending |=> !cmd_ready; endproperty
  a_wai: assert property (p_wai) else $error("wait did not hold");
  property p_wake; clk_en && !cmd_ready && !op_pending |=> cmd_ready; endproperty
  a_wake: assert property (p_wake) else $error("wait did not release");
  property p_qhold; clk_en && !cmd_ready && op_pending |=> !query_done; endproperty
  a_qhold: assert property (p_qhold) else $error("query answered during wait");
  property p_cls; take && cmd_code == `CMD_CLS |=> err_queue_clear; endproperty
  a_cls: assert property (p_cls) else $error("clear status missed queue");
  property p_eqc; clk_en ##1 err_queue_clear |-> $past(power_on || cmd_code == `CMD_CLS && take);
  endproperty
  a_eqc: assert property (p_eqc) else $error("spurious queue clear");
  property p_raw; status_byte[1:0] == 2'h0; endproperty
  a_raw: assert property (p_raw) else $error("reserved status bits set");
  property p_ist; clk_en && query_valid && query_code == `QRY_IST |=> query_data[15:1] == 15'h0000;
  endproperty
  a_ist: assert property (p_ist) else $error("ist answer too wide");
  c_wai: cover property (take && cmd_code == `CMD_WAI && op_pending);
  c_srq: cover property (srq_out);
  c_cls: cover property (err_queue_clear);
  c_hold: cover property (clk_en && !cmd_ready && op_pending && query_valid);
endmodule
`default_nettype wire

// ### bench/srq_poll_model.sv
// Bus controller side: counts service requests raised on the line.
// Assumes srq_line is a registered level on the block's clock.
`timescale 1ns/1ps
`default_nettype none
module srq_poll_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic srq_line,
  output int       n_req
);
  logic last_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      n_req <= 0;
    end else begin
      last_q <= srq_line;
      if (srq_line && !last_q) n_req <= n_req + 1;
    end
  end
endmodule
`default_nettype wire

// ### bench/status_reporting_service_request_tb.sv
// Self-checking bench for the status reporting block.
// Assumes design, checker and controller model compiled alongside.
`include "status_report_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module status_reporting_service_request_tb;
  logic        clock = 0, rst_n = 0, cmd_valid = 0, query_valid = 0, op_pending = 0, mav = 0;
  logic        cen = 1, pwr = 0, ques = 0, errq = 0;
  logic [3:0]  cmd_code = 0, query_code = 0;
  logic [15:0] cmd_data = 0, v;
  logic [14:0] oper_c = 0, reg_c = 0;
  logic [7:0]  ev = 0;
  logic [31:0] lf = 32'hD18B6982;
  wire logic   cmd_ready, query_done, eqc, srq_out, ist_out;
  wire logic [15:0] query_data;
  wire logic [7:0]  status_byte;
  int          n_mismatch = 0, tests_run = 0, n_req, i;
  logic [3:0]  wc[5] = '{`CMD_WR_OPER_EN, `CMD_WR_OPER_PTR, `CMD_WR_OPER_NTR, `CMD_WR_REG_EN, `CMD_WR_REG_PTR};
  logic [3:0]  rc[5] = '{`QRY_OPER_EN, `QRY_OPER_PTR, `QRY_OPER_NTR, `QRY_REG_EN, `QRY_REG_PTR};
  status_reporting_service_request DUT (.clock(clock), .rst_n(rst_n), .clk_en(cen),
    .power_on(pwr), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .query_valid(query_valid), .query_code(query_code),
    .query_done(query_done), .query_data(query_data), .oper_cond_in(oper_c),
    .reg_cond_in(reg_c), .ques_summary_in(ques), .err_queue_nonempty(errq),
    .msg_available(mav), .std_event_set(ev), .op_pending(op_pending),
    .err_queue_clear(eqc), .srq_out(srq_out), .ist_out(ist_out), .status_byte(status_byte));
  srq_poll_model ctrl (.clock(clock), .rst_n(rst_n), .srq_line(srq_out), .n_req(n_req));
  initial forever #20 clock = ~clock;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected read-back of an operation or regulating enable or filter write
  function automatic logic [15:0] as_mask(input logic [15:0] d);
    return d & 16'h7FFF;
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Ready is sampled at the falling edge, so it is stable over the taking edge
  task automatic cmd(input logic [3:0] c, input logic [15:0] d);
    int k;
    k = 0;
    @(negedge clock);
    cmd_code = c;
    cmd_data = d;
    cmd_valid = 1;
    while (cmd_ready !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    if (cmd_ready !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: command never taken", $time);
      conclude();
    end
    @(negedge clock);
    cmd_valid = 0;
  endtask
  task automatic qc(input logic [3:0] c, input logic [15:0] e);
    @(negedge clock);
    query_code = c;
    query_valid = 1;
    @(negedge clock);
    query_valid = 0;
    chk({15'h0000, query_done}, 16'h0001);
    chk(query_data, e);
  endtask
  ////////////////////////////////////////
  initial begin
    w(20);
    rst_n = 1;
    qc(`QRY_OPER_EN, 16'h0000);
    qc(`QRY_OPER_PTR, 16'h7FFF);
    qc(`QRY_REG_EN, 16'h7FFF);
    qc(`QRY_PSC, 16'h0001);
    qc(`QRY_SRE, 16'h0000);
    for (i = 0; i < 20; i++) begin
      lf = lfsr(lf);
      reg_c = lf[30:16];
      v = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h0000 : {1'b0, lf[14:0]};
      cmd(wc[i % 5], v);
      qc(rc[i % 5], as_mask(v));
    end
    cmd(`CMD_WR_OPER_PTR, 16'h7FFF);
    cmd(`CMD_WR_OPER_EN, 16'h0000);
    cmd(`CMD_WR_SRE, 16'h0080);
    cmd(`CMD_WR_PRE, 16'h0080);
    cmd(`CMD_WR_ESE, 16'h0010);
    oper_c = 15'h0001;
    w(8);
    cmd(`CMD_PRESET, 16'h0000);
    qc(`QRY_OPER_EN, 16'h0000);
    qc(`QRY_OPER_PTR, 16'h7FFF);
    qc(`QRY_OPER_NTR, 16'h0000);
    qc(`QRY_REG_EN, 16'h7FFF);
    qc(`QRY_REG_PTR, 16'h7FFF);
    qc(`QRY_SRE, 16'h0080);
    qc(`QRY_PRE, 16'h0080);
    qc(`QRY_OPER_EVT, 16'h0001);
    qc(`QRY_OPER_EVT, 16'h0000);
    cmd(`CMD_WR_OPER_EN, 16'h0001);
    oper_c = 15'h0000;
    w(8);
    oper_c = 15'h0001;
    w(8);
    chk(status_byte[7], 1);
    chk(srq_out, 1);
    chk(ist_out, 1);
    qc(`QRY_STB, 16'h00C0);
    qc(`QRY_IST, 16'h0001);
    cmd(`CMD_WR_SRE, 16'h0000);
    mav = 1;
    w(4);
    chk({srq_out, status_byte[4]}, 16'h0001);
    ev = 8'h10;
    w(1);
    ev = 8'h00;
    w(6);
    chk(status_byte[5], 1);
    qc(`QRY_ESR, 16'h0010);
    qc(`QRY_ESR, 16'h0000);
    cmd(`CMD_CLS, 16'h0000);
    w(4);
    qc(`QRY_OPER_EVT, 16'h0000);
    chk(status_byte[7], 0);
    op_pending = 1;
    cmd(`CMD_OPC, 16'h0000);
    cmd(`CMD_WAI, 16'h0000);
    w(3);
    chk(cmd_ready, 0);
    @(negedge clock);
    query_code = `QRY_ESE;
    query_valid = 1;
    @(negedge clock);
    query_valid = 0;
    chk({15'h0000, query_done}, 16'h0000);
    op_pending = 0;
    w(1);
    chk({15'h0000, query_done}, 16'h0001);
    chk(query_data, 16'h0010);
    w(2);
    chk(cmd_ready, 1);
    qc(`QRY_ESR, 16'h0001);
    ques = 1;
    errq = 1;
    w(4);
    chk(status_byte[3:2], 16'h0003);
    ques = 0;
    errq = 0;
    cen = 0;
    mav = 0;
    w(3);
    chk(status_byte[4], 16'h0001);
    cen = 1;
    w(2);
    chk(status_byte[4], 16'h0000);
    pwr = 1;
    w(1);
    pwr = 0;
    w(2);
    qc(`QRY_ESE, 16'h0000);
    qc(`QRY_PRE, 16'h0000);
    cmd(`CMD_WR_PSC, 16'h0000);
    cmd(`CMD_WR_ESE, 16'h0020);
    pwr = 1;
    w(1);
    pwr = 0;
    w(2);
    qc(`QRY_ESE, 16'h0020);
    chk(n_req[15:0], 16'h0001);
    conclude();
  end
endmodule
bind status_reporting_service_request status_props u_props (.clock(clock), .rst_n(rst_n),
  .clk_en(clk_en), .power_on(power_on), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_ready(cmd_ready), .query_valid(query_valid), .query_code(query_code),
  .query_done(query_done), .query_data(query_data), .op_pending(op_pending),
  .err_queue_clear(err_queue_clear), .srq_out(srq_out), .status_byte(status_byte));
`default_nettype wire
